// File: core/smsp_pkg.sv
// Purpose: shared constants and types for the management bus select and
//   pin configuration block and its host end
// Assumes: one 125 MHz clock, synchronous pin inputs
// Notes: register offsets and function codes live here only
//
// Notes on behaviour
// - device answers bus only while select high
// - host drops select after transaction; device disengages
// - lone device may keep select held high
// - seven-bit address, no address resolution protocol
// - three configurable general-purpose pins
// - clock-present status routable to pin zero
// - upper four control bits pick pin function
// - every pin drives written level or samples
// - pin zero monitors clock, clock-present, reset
// - pin one reset/lane loss; pin two clock
// - bits 3:2 select no pull, pulldown, pullup
// - bit one enables input buffer
// - bit zero selects drive or high impedance
package smsp_pkg;

  // ==========================================================
  // management bus
  localparam logic [6:0] SMSP_DEV_ADDR_DEFAULT = 7'h57;
  localparam logic [3:0] SMSP_BYTE_BITS = 4'h8;
  localparam logic [3:0] SMSP_TX_LAST = 4'h7;
  localparam int SMSP_SCL_PERIOD_NS = 10000;
  localparam int SMSP_CLK_PERIOD_NS = 8;
  localparam int SMSP_QTR_CYCLES = SMSP_SCL_PERIOD_NS / (4 * SMSP_CLK_PERIOD_NS);
  localparam logic [8:0] SMSP_QTR_LAST = 9'(SMSP_QTR_CYCLES - 1);

  // ==========================================================
  // register map
  localparam int SMSP_PINS = 3;
  localparam int SMSP_LANES = 5;
  localparam logic [7:0] SMSP_OFS_PIN0_CFG = 8'h20;
  localparam logic [7:0] SMSP_OFS_PIN_LEVEL = 8'h23;
  localparam logic [7:0] SMSP_CFG_RESET = 8'h00;
  localparam logic [2:0] SMSP_LEVEL_RESET = 3'h0;
  localparam int SMSP_FN_MSB = 7;
  localparam int SMSP_FN_LSB = 4;
  localparam int SMSP_BIAS_MSB = 3;
  localparam int SMSP_BIAS_LSB = 2;
  localparam int SMSP_IBUF_BIT = 1;
  localparam int SMSP_DRIVE_BIT = 0;
  localparam logic [1:0] SMSP_BIAS_PULLDOWN = 2'h1;
  localparam logic [1:0] SMSP_BIAS_PULLUP = 2'h2;

  // ==========================================================
  // pin function codes
  localparam logic [3:0] SMSP_FN_DRIVE = 4'h0;
  localparam logic [3:0] SMSP_FN_SAMPLE = 4'h1;
  localparam logic [3:0] SMSP_FN0_CLOCK = 4'h2;
  localparam logic [3:0] SMSP_FN0_CLK_PRESENT = 4'h3;
  localparam logic [3:0] SMSP_FN0_POR = 4'h4;
  localparam logic [3:0] SMSP_FN1_POR = 4'h2;
  localparam logic [3:0] SMSP_FN1_LOS_BASE = 4'h3;
  localparam logic [3:0] SMSP_FN2_SER_CLOCK = 4'h2;

  // ==========================================================
  // host transaction byte slots
  localparam logic [1:0] SMSP_IX_ADDR = 2'h0;
  localparam logic [1:0] SMSP_IX_REG = 2'h1;
  localparam logic [1:0] SMSP_IX_DATA = 2'h2;
  localparam logic [1:0] SMSP_IX_RDATA = 2'h3;

  typedef enum logic [2:0] {DS_IDLE, DS_RX, DS_ACK, DS_TX, DS_RACK}
    smsp_dev_st_t;
  typedef enum logic [1:0] {K_ADDR, K_REG, K_DATA} smsp_kind_t;
  typedef enum logic [2:0] {HS_IDLE, HS_SEL, HS_START, HS_BIT, HS_STOP,
    HS_DONE} smsp_host_st_t;

endpackage

// File: core/smsp_if.sv
// Purpose: two-wire management bus plus select between host and device
// Assumes: open-drain wires with pullups resolved here
// Notes: each party gives value and enable; wire is low if any drives 0
`timescale 1ns/1ns
`default_nettype none
interface smsp_if;
  logic mgmt_bus_select;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport host (output mgmt_bus_select, output host_scl_o,
    output host_scl_oe, output host_sda_o, output host_sda_oe,
    input scl, input sda);
  modport dev (input mgmt_bus_select, input scl, input sda,
    output dev_sda_o, output dev_sda_oe);
endinterface
`default_nettype wire

// File: core/smsp_device.sv
// Purpose: device end: select-gated bus slave and three pin controllers
// Assumes: bus wires synchronous to ref_clk, host does not stretch
// Notes: register pointer auto-increments on writes and reads
`timescale 1ns/1ns
`default_nettype none
module smsp_device #(
  parameter logic [6:0] DEV_ADDR = smsp_pkg::SMSP_DEV_ADDR_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  smsp_if.dev bus,
  input wire logic [smsp_pkg::SMSP_PINS-1:0] gpio_in,
  output logic [smsp_pkg::SMSP_PINS-1:0] gpio_out,
  output logic [smsp_pkg::SMSP_PINS-1:0] gpio_oe,
  output logic [smsp_pkg::SMSP_PINS-1:0] gpio_pull_up,
  output logic [smsp_pkg::SMSP_PINS-1:0] gpio_pull_down,
  output logic [smsp_pkg::SMSP_PINS-1:0] gpio_ibuf_en,
  input wire logic host_ddr_clock,
  input wire logic input_clock_present,
  input wire logic por_active,
  input wire logic [smsp_pkg::SMSP_LANES-1:0] lane_signal_absent,
  input wire logic serializer_clock
);
  import smsp_pkg::*;

  // ==========================================================
  // bus slave state
  smsp_dev_st_t st_q, st_d;
  smsp_kind_t kind_q, kind_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] ptr_q, ptr_d;
  logic drv_q, drv_d;
  logic rw_q, rw_d;
  logic nack_q, nack_d;
  logic scl_q, sda_q;
  logic [7:0] cfg_q [SMSP_PINS];
  logic [7:0] cfg_d [SMSP_PINS];
  logic [2:0] lvl_q, lvl_d;
  logic [2:0] smp_q, smp_d;
  logic [2:0] out_q, out_d;
  logic [7:0] rd_byte;
  logic scl_rise, scl_fall, start_ev, stop_ev;

  assign scl_rise = bus.scl && !scl_q;
  assign scl_fall = !bus.scl && scl_q;
  assign start_ev = bus.scl && scl_q && sda_q && !bus.sda;
  assign stop_ev = bus.scl && scl_q && !sda_q && bus.sda;

  // open drain: only ever pulls low
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = drv_q;

  always_comb begin
    rd_byte = 8'h00;
    for (int i = 0; i < SMSP_PINS; i++) begin
      if (ptr_q == SMSP_OFS_PIN0_CFG + 8'(i)) begin
        rd_byte = cfg_q[i];
      end
    end
    if (ptr_q == SMSP_OFS_PIN_LEVEL) begin
      rd_byte = {5'h00, smp_q};
    end
  end

  always_comb begin
    st_d = st_q;
    kind_d = kind_q;
    bit_d = bit_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    drv_d = drv_q;
    rw_d = rw_q;
    nack_d = nack_q;
    cfg_d = cfg_q;
    lvl_d = lvl_q;
    if (!bus.mgmt_bus_select) begin
      // deselected: release the wire and ignore all traffic
      st_d = DS_IDLE;
      drv_d = 1'b0;
    end else if (start_ev) begin
      st_d = DS_RX;
      kind_d = K_ADDR;
      bit_d = 4'h0;
      drv_d = 1'b0;
    end else if (stop_ev) begin
      st_d = DS_IDLE;
      drv_d = 1'b0;
    end else begin
      unique case (st_q)
        DS_IDLE: begin
        end
        DS_RX: begin
          if (scl_rise && bit_q != SMSP_BYTE_BITS) begin
            sh_d = {sh_q[6:0], bus.sda};
            bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == SMSP_BYTE_BITS) begin
            bit_d = 4'h0;
            drv_d = 1'b1;
            st_d = DS_ACK;
            unique case (kind_q)
              K_ADDR: begin
                // no address resolution: a mismatch just goes quiet
                if (sh_q[7:1] == DEV_ADDR) begin
                  rw_d = sh_q[0];
                end else begin
                  drv_d = 1'b0;
                  st_d = DS_IDLE;
                end
              end
              K_REG: ptr_d = sh_q;
              K_DATA: begin
                for (int i = 0; i < SMSP_PINS; i++) begin
                  if (ptr_q == SMSP_OFS_PIN0_CFG + 8'(i)) begin
                    cfg_d[i] = sh_q;
                  end
                end
                if (ptr_q == SMSP_OFS_PIN_LEVEL) begin
                  lvl_d = sh_q[2:0];
                end
                ptr_d = ptr_q + 8'h01;
              end
            endcase
          end
        end
        DS_ACK: begin
          if (scl_fall) begin
            if (kind_q == K_ADDR && rw_q) begin
              st_d = DS_TX;
              sh_d = rd_byte;
              drv_d = !rd_byte[7];
              ptr_d = ptr_q + 8'h01;
            end else begin
              st_d = DS_RX;
              drv_d = 1'b0;
              kind_d = (kind_q == K_ADDR) ? K_REG : K_DATA;
            end
          end
        end
        DS_TX: begin
          if (scl_fall) begin
            if (bit_q == SMSP_TX_LAST) begin
              drv_d = 1'b0;
              bit_d = 4'h0;
              st_d = DS_RACK;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              drv_d = !sh_q[6];
              bit_d = bit_q + 4'h1;
            end
          end
        end
        DS_RACK: begin
          if (scl_rise) begin
            nack_d = bus.sda;
          end else if (scl_fall) begin
            if (nack_q) begin
              st_d = DS_IDLE;
            end else begin
              st_d = DS_TX;
              sh_d = rd_byte;
              drv_d = !rd_byte[7];
              ptr_d = ptr_q + 8'h01;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= DS_IDLE;
      kind_q <= K_ADDR;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      drv_q <= 1'b0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      for (int i = 0; i < SMSP_PINS; i++) begin
        cfg_q[i] <= SMSP_CFG_RESET;
      end
      lvl_q <= SMSP_LEVEL_RESET;
    end else if (clk_en) begin
      st_q <= st_d;
      kind_q <= kind_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      drv_q <= drv_d;
      rw_q <= rw_d;
      nack_q <= nack_d;
      scl_q <= bus.scl;
      sda_q <= bus.sda;
      cfg_q <= cfg_d;
      lvl_q <= lvl_d;
    end
  end

  // ==========================================================
  // pin function muxes
  // clocks routed out pass a flop, so only slow clocks survive intact
  logic [3:0] fn [SMSP_PINS];

  always_comb begin
    for (int i = 0; i < SMSP_PINS; i++) begin
      fn[i] = cfg_q[i][SMSP_FN_MSB:SMSP_FN_LSB];
      gpio_oe[i] = cfg_q[i][SMSP_DRIVE_BIT];
      gpio_ibuf_en[i] = cfg_q[i][SMSP_IBUF_BIT];
      // reserved bias code falls through to no pull
      gpio_pull_up[i] = cfg_q[i][SMSP_BIAS_MSB:SMSP_BIAS_LSB]
        == SMSP_BIAS_PULLUP;
      gpio_pull_down[i] = cfg_q[i][SMSP_BIAS_MSB:SMSP_BIAS_LSB]
        == SMSP_BIAS_PULLDOWN;
      smp_d[i] = gpio_in[i] && cfg_q[i][SMSP_IBUF_BIT];
    end
    out_d = 3'h0;
    unique case (fn[0])
      SMSP_FN_DRIVE: out_d[0] = lvl_q[0];
      SMSP_FN0_CLOCK: out_d[0] = host_ddr_clock;
      SMSP_FN0_CLK_PRESENT: out_d[0] = input_clock_present;
      SMSP_FN0_POR: out_d[0] = por_active;
      default: out_d[0] = 1'b0;
    endcase
    if (fn[1] == SMSP_FN_DRIVE) begin
      out_d[1] = lvl_q[1];
    end else if (fn[1] == SMSP_FN1_POR) begin
      out_d[1] = por_active;
    end else begin
      for (int l = 0; l < SMSP_LANES; l++) begin
        if (fn[1] == SMSP_FN1_LOS_BASE + 4'(l)) begin
          out_d[1] = lane_signal_absent[l];
        end
      end
    end
    unique case (fn[2])
      SMSP_FN_DRIVE: out_d[2] = lvl_q[2];
      SMSP_FN2_SER_CLOCK: out_d[2] = serializer_clock;
      default: out_d[2] = 1'b0;
    endcase
  end

  assign gpio_out = out_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 3'h0;
      smp_q <= 3'h0;
    end else if (clk_en) begin
      out_q <= out_d;
      smp_q <= smp_d;
    end
  end
endmodule
`default_nettype wire

// File: core/smsp_host.sv
// Purpose: host end: bus master issuing single register writes and reads
// Assumes: 100 kHz bus clock made from ref_clk, no clock stretching
// Notes: select rises one full bit (four quarters) before start, falls after stop
`timescale 1ns/1ns
`default_nettype none
module smsp_host (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  smsp_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [6:0] cmd_dev_addr,
  input wire logic [7:0] cmd_reg,
  input wire logic [7:0] cmd_wdata,
  input wire logic select_hold,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_nack
);
  import smsp_pkg::*;

  // ==========================================================
  // sequencer
  smsp_host_st_t st_q, st_d;
  logic [8:0] cnt_q, cnt_d;
  logic [1:0] ph_q, ph_d;
  logic [1:0] idx_q, idx_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic rd_q, rd_d;
  logic [6:0] addr_q, addr_d;
  logic [7:0] reg_q, reg_d;
  logic [7:0] wd_q, wd_d;
  logic scl_rel_q, scl_rel_d;
  logic sda_rel_q, sda_rel_d;
  logic sel_q, sel_d;
  logic nack_q, nack_d;
  logic rv_q, rv_d;
  logic [7:0] rdata_q, rdata_d;
  logic tick, rdbyte;

  assign tick = (cnt_q == SMSP_QTR_LAST);
  assign rdbyte = (idx_q == SMSP_IX_RDATA);
  assign cmd_ready = (st_q == HS_IDLE);
  assign bus.mgmt_bus_select = sel_q;
  assign bus.host_scl_o = 1'b0;
  assign bus.host_scl_oe = !scl_rel_q;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = !sda_rel_q;
  assign rsp_valid = rv_q;
  assign rsp_rdata = rdata_q;
  assign rsp_nack = nack_q;

  always_comb begin
    st_d = st_q;
    cnt_d = (st_q == HS_IDLE || tick) ? 9'h000 : cnt_q + 9'h001;
    ph_d = ph_q;
    idx_d = idx_q;
    bit_d = bit_q;
    sh_d = sh_q;
    rd_d = rd_q;
    addr_d = addr_q;
    reg_d = reg_q;
    wd_d = wd_q;
    scl_rel_d = scl_rel_q;
    sda_rel_d = sda_rel_q;
    sel_d = sel_q;
    nack_d = nack_q;
    rv_d = 1'b0;
    rdata_d = rdata_q;
    unique case (st_q)
      HS_IDLE: begin
        sel_d = select_hold;
        if (cmd_valid) begin
          st_d = HS_SEL;
          sel_d = 1'b1;
          rd_d = cmd_read;
          addr_d = cmd_dev_addr;
          reg_d = cmd_reg;
          wd_d = cmd_wdata;
          idx_d = SMSP_IX_ADDR;
          nack_d = 1'b0;
        end
      end
      HS_SEL: begin
        if (tick) begin
          st_d = HS_START;
          ph_d = 2'h0;
        end
      end
      HS_START: begin
        if (tick) begin
          ph_d = ph_q + 2'h1;
          unique case (ph_q)
            2'h0: sda_rel_d = 1'b1;
            2'h1: scl_rel_d = 1'b1;
            2'h2: sda_rel_d = 1'b0;
            2'h3: begin
              scl_rel_d = 1'b0;
              st_d = HS_BIT;
              bit_d = 4'h0;
              sh_d = {addr_q, idx_q == SMSP_IX_DATA};
            end
          endcase
        end
      end
      HS_BIT: begin
        if (tick) begin
          ph_d = ph_q + 2'h1;
          unique case (ph_q)
            2'h0: sda_rel_d = (bit_q != SMSP_BYTE_BITS && !rdbyte) ? sh_q[7]
              : 1'b1;
            2'h1: scl_rel_d = 1'b1;
            2'h2: begin
              if (bit_q != SMSP_BYTE_BITS && rdbyte) begin
                sh_d = {sh_q[6:0], bus.sda};
              end else if (bit_q == SMSP_BYTE_BITS && !rdbyte) begin
                nack_d = bus.sda;
              end
            end
            2'h3: begin
              scl_rel_d = 1'b0;
              if (bit_q != SMSP_BYTE_BITS) begin
                bit_d = bit_q + 4'h1;
                if (!rdbyte) begin
                  sh_d = {sh_q[6:0], 1'b0};
                end
              end else begin
                bit_d = 4'h0;
                idx_d = idx_q + 2'h1;
                if (!rdbyte && nack_q) begin
                  st_d = HS_STOP;
                end else if (idx_q == SMSP_IX_ADDR) begin
                  sh_d = reg_q;
                end else if (idx_q == SMSP_IX_REG) begin
                  sh_d = wd_q;
                  if (rd_q) begin
                    st_d = HS_START;
                  end
                end else if (idx_q == SMSP_IX_DATA) begin
                  if (!rd_q) begin
                    st_d = HS_STOP;
                  end
                end else begin
                  rdata_d = sh_q;
                  st_d = HS_STOP;
                end
              end
            end
          endcase
        end
      end
      HS_STOP: begin
        if (tick) begin
          ph_d = ph_q + 2'h1;
          unique case (ph_q)
            2'h0: sda_rel_d = 1'b0;
            2'h1: scl_rel_d = 1'b1;
            2'h2: sda_rel_d = 1'b1;
            2'h3: st_d = HS_DONE;
          endcase
        end
      end
      HS_DONE: begin
        // released only after stop so a shared bus is free for others
        sel_d = select_hold;
        rv_d = 1'b1;
        st_d = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= HS_IDLE;
      cnt_q <= 9'h000;
      ph_q <= 2'h0;
      idx_q <= SMSP_IX_ADDR;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      rd_q <= 1'b0;
      addr_q <= 7'h00;
      reg_q <= 8'h00;
      wd_q <= 8'h00;
      scl_rel_q <= 1'b1;
      sda_rel_q <= 1'b1;
      sel_q <= 1'b0;
      nack_q <= 1'b0;
      rv_q <= 1'b0;
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      ph_q <= ph_d;
      idx_q <= idx_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      rd_q <= rd_d;
      addr_q <= addr_d;
      reg_q <= reg_d;
      wd_q <= wd_d;
      scl_rel_q <= scl_rel_d;
      sda_rel_q <= sda_rel_d;
      sel_q <= sel_d;
      nack_q <= nack_d;
      rv_q <= rv_d;
      rdata_q <= rdata_d;
    end
  end
endmodule
`default_nettype wire

// File: verification/smsp_assertions.sv
// Purpose: wire-level checks on the select-gated management bus
// Assumes: one clock domain, async active-low reset
// Notes: sees only the interface signals, instantiated beside it
`timescale 1ns/1ns
`default_nettype none
module smsp_assertions (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic mgmt_bus_select,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // select gating
  AST_SEL_RELEASE: assert property (
    !mgmt_bus_select ##1 !mgmt_bus_select |-> !dev_sda_oe)
    else $error("device still pulls sda while deselected");
  AST_DEV_OE_NEEDS_SEL: assert property (
    dev_sda_oe |-> $past(mgmt_bus_select))
    else $error("device pulled sda without select");
  AST_SCL_NEEDS_SEL: assert property (
    host_scl_oe |-> mgmt_bus_select)
    else $error("bus clock moved without select");
  AST_START_NEEDS_SEL: assert property (
    $fell(sda) && scl |-> mgmt_bus_select)
    else $error("start condition without select");
  // select must lead the start by a quiet stretch
  AST_SEL_LEAD_IDLE: assert property (
    $rose(mgmt_bus_select) |-> (scl && sda) [*8])
    else $error("bus not idle after select rose");
  AST_SEL_FALL_IDLE: assert property (
    $fell(mgmt_bus_select) |-> scl && sda && !host_scl_oe)
    else $error("select dropped inside a transfer");

  // ==========================================================
  // wire discipline
  AST_DEV_SDA_STABLE: assert property (
    $changed(dev_sda_oe) |-> !scl)
    else $error("device changed sda while scl high");
  AST_DRIVE_LOW_ONLY: assert property (
    !host_scl_o && !host_sda_o && !dev_sda_o)
    else $error("open-drain value not low");
  AST_SCL_HIGH_HOLD: assert property (
    $rose(scl) |-> scl [*8])
    else $error("scl high phase too short");
endmodule
`default_nettype wire

// File: verification/smbus_select_and_pin_config_tb_top.sv
// Purpose: host and device joined over the bus, plus a deselected twin
// Assumes: quarter bit of 312 cycles, so only three transfers fit
// Notes: twin device shares wires but its select is held low
`timescale 1ns/1ns
`default_nettype none
module smbus_select_and_pin_config_tb_top;
  import smsp_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [6:0] cmd_dev_addr = 7'h00;
  logic [7:0] cmd_reg = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic select_hold = 1'b0;
  logic [2:0] gpio_in = 3'h5;
  logic icp = 1'b0;
  logic por = 1'b0;
  logic [4:0] lane_absent = 5'h00;
  logic cmd_ready, rsp_valid, rsp_nack, d2_bad;
  logic [7:0] rsp_rdata;
  logic [2:0] gpio_out, gpio_oe, pull_up, pull_down, ibuf_en, d2_oe;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  smsp_if bus();
  smsp_if bus2();
  assign bus2.mgmt_bus_select = 1'b0;
  assign bus2.host_scl_o = bus.host_scl_o;
  assign bus2.host_scl_oe = bus.host_scl_oe;
  assign bus2.host_sda_o = bus.host_sda_o;
  assign bus2.host_sda_oe = bus.host_sda_oe;

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // design ends
  smsp_host i_smsp_host (.ref_clk(ref_clk), .rst_n(rst_n),
    .clk_en(clk_en), .bus(bus), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read),
    .cmd_dev_addr(cmd_dev_addr), .cmd_reg(cmd_reg),
    .cmd_wdata(cmd_wdata), .select_hold(select_hold),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack));
  smsp_device i_smsp_device (.ref_clk(ref_clk), .rst_n(rst_n),
    .clk_en(clk_en), .bus(bus), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_pull_up(pull_up),
    .gpio_pull_down(pull_down), .gpio_ibuf_en(ibuf_en),
    .host_ddr_clock(ref_clk), .input_clock_present(icp),
    .por_active(por), .lane_signal_absent(lane_absent),
    .serializer_clock(ref_clk));
  // same address as the first: only select keeps it out
  smsp_device i_smsp_device_2 (.ref_clk(ref_clk), .rst_n(rst_n),
    .clk_en(clk_en), .bus(bus2), .gpio_in(gpio_in), .gpio_out(),
    .gpio_oe(d2_oe), .gpio_pull_up(), .gpio_pull_down(),
    .gpio_ibuf_en(), .host_ddr_clock(ref_clk),
    .input_clock_present(icp), .por_active(por),
    .lane_signal_absent(lane_absent), .serializer_clock(ref_clk));
  smsp_assertions i_smsp_assertions (.ref_clk(ref_clk), .rst_n(rst_n),
    .mgmt_bus_select(bus.mgmt_bus_select),
    .host_scl_o(bus.host_scl_o), .host_scl_oe(bus.host_scl_oe),
    .host_sda_o(bus.host_sda_o), .host_sda_oe(bus.host_sda_oe),
    .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe),
    .scl(bus.scl), .sda(bus.sda));

  // ==========================================================
  // helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one host command, held until taken, then wait for the response
  task automatic xfer(input logic rd, input logic [6:0] a,
    input logic [7:0] r, input logic [7:0] wd);
    int n;
    @(negedge ref_clk);
    cmd_read = rd;
    cmd_dev_addr = a;
    cmd_reg = r;
    cmd_wdata = wd;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 60000) begin
      @(negedge ref_clk);
      n++;
    end
    // a hung transfer must count, not slip through silently
    check(rsp_valid, 1'b1);
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    // three transfers need about 99k cycles
    if (cycles == 105000) begin
      num_errors++;
      print_verdict();
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      d2_bad <= 1'b0;
    end else if (bus2.dev_sda_oe !== 1'b0) begin
      d2_bad <= 1'b1;
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    check(cmd_ready, 1'b1);
    check(bus.mgmt_bus_select, 1'b0);
    // function 3 on pin 0, pullup, driving, so input buffer kept off
    xfer(1'b0, SMSP_DEV_ADDR_DEFAULT, SMSP_OFS_PIN0_CFG, 8'h39);
    check(rsp_nack, 1'b0);
    check(bus.mgmt_bus_select, 1'b0);
    check(gpio_oe, 3'h1);
    check(pull_up, 3'h1);
    check(pull_down, 3'h0);
    check(ibuf_en, 3'h0);
    check(d2_oe, 3'h0);
    icp = 1'b1;
    repeat (2) @(negedge ref_clk);
    check(gpio_out, 3'h1);
    icp = 1'b0;
    repeat (2) @(negedge ref_clk);
    check(gpio_out, 3'h0);
    // unselected status sources must not leak onto any pin
    por = 1'b1;
    lane_absent = 5'h1f;
    repeat (2) @(negedge ref_clk);
    check(gpio_out, 3'h0);
    // address off by the last of its seven bits
    xfer(1'b0, 7'h56, SMSP_OFS_PIN0_CFG + 8'h01, 8'h09);
    check(rsp_nack, 1'b1);
    check(gpio_oe, 3'h1);
    select_hold = 1'b1;
    xfer(1'b1, SMSP_DEV_ADDR_DEFAULT, SMSP_OFS_PIN0_CFG, 8'h00);
    check(rsp_rdata, 8'h39);
    check(rsp_nack, 1'b0);
    @(negedge ref_clk);
    check(bus.mgmt_bus_select, 1'b1);
    check(d2_bad, 1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire
